// file: include/pew_map.svh
`ifndef PEW_MAP_SVH
`define PEW_MAP_SVH

// ****************************************
// clock and printed times
// ****************************************
`define PEW_CLK_NS 10
`define PEW_WP_NS 100
`define PEW_DH_NS 10
`define PEW_WPH_NS 200
`define PEW_CE_ACC_NS 150
`define PEW_OHZ_NS 50
`define PEW_BLC_MAX_NS 100000
`define PEW_WC_MAX_NS 10000000
`define PEW_DW_NS 10000

// ****************************************
// derived cycle counts
// ****************************************
`define PEW_SYNC_CYC 3
`define PEW_WP_CYC ((`PEW_WP_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_DH_CYC ((`PEW_DH_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_WPH_CYC ((`PEW_WPH_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_RD_CYC (((`PEW_CE_ACC_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS) + `PEW_SYNC_CYC)
`define PEW_OHZ_CYC ((`PEW_OHZ_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_DW_CYC ((`PEW_DW_NS + `PEW_CLK_NS - 1) / `PEW_CLK_NS)
`define PEW_LOAD_MARGIN_CYC 20

// ****************************************
// array layout and status codes
// ****************************************
`define PEW_ADDR_W 15
`define PEW_DATA_W 8
`define PEW_PAGE_LSB 6
`define PEW_PAGE_BYTES 64
`define PEW_POLL_BIT 7
`define PEW_TOGGLE_BIT 6
`define PEW_TMR_W 20
`define PEW_ST_OK 2'h0
`define PEW_ST_TIMEOUT 2'h1
`define PEW_ST_PROTECTED 2'h2

`endif

// file: include/pew_pkg.sv
`include "pew_map.svh"

package pew_pkg;

  // ****************************************
  // controller states
  // ****************************************
  typedef enum logic [3:0] {
    PEW_IDLE = 4'h0,
    PEW_RD_ACT = 4'h1,
    PEW_RD_END = 4'h2,
    PEW_WR_LOW = 4'h3,
    PEW_WR_RISE = 4'h4,
    PEW_WR_GAP = 4'h5,
    PEW_LOAD_OPEN = 4'h6,
    PEW_SETTLE = 4'h7,
    PEW_RECOVER = 4'h8
  } pew_state_t;

  typedef logic [`PEW_TMR_W-1:0] pew_tick_t;

endpackage : pew_pkg

// file: include/pew_tmr_if.sv
`include "pew_map.svh"

// ****************************************
// long interval timer carrier
// ****************************************
interface pew_tmr_if;
  logic load;
  pew_pkg::pew_tick_t value;
  logic expired;

  modport ctrl (output load, output value, input expired);
  modport tmr (input load, input value, output expired);
endinterface : pew_tmr_if

// file: tb/pew_host_asserts.sv
// ****************************************
// host pin protocol checks
// ****************************************
module pew_host_asserts (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  // user side
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic req_write_in,
  input wire logic [14:0] req_addr_in,
  input wire logic rsp_valid_out,
  input wire logic busy_out,
  // memory pins
  input wire logic chip_select_n_out,
  input wire logic output_gate_n_out,
  input wire logic write_strobe_n_out,
  input wire logic [14:0] byte_address_out,
  input wire logic [7:0] data_lines_out,
  input wire logic data_lines_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // strobe low ten cycles, then high
  sequence s_we_pulse;
    (!write_strobe_n_out)[*8] ##1 (!write_strobe_n_out)[*2] ##1 write_strobe_n_out;
  endsequence
  // read held eighteen cycles, then both released
  sequence s_rd_pulse;
    (!output_gate_n_out && !chip_select_n_out)[*8] ##1
      (!output_gate_n_out && !chip_select_n_out)[*8] ##1
      (!output_gate_n_out && !chip_select_n_out)[*2] ##1
      (output_gate_n_out && chip_select_n_out);
  endsequence
  property p_we_width;
    $fell(write_strobe_n_out) |-> s_we_pulse;
  endproperty
  property p_wr_gate;
    !write_strobe_n_out |-> output_gate_n_out && !chip_select_n_out;
  endproperty
  property p_no_fight;
    data_lines_oe_out |-> output_gate_n_out;
  endproperty
  property p_addr_hold;
    !write_strobe_n_out && !$fell(write_strobe_n_out)
      |-> $stable(byte_address_out) && $stable(data_lines_out);
  endproperty
  property p_data_hold;
    $rose(write_strobe_n_out) |-> !chip_select_n_out && data_lines_oe_out
      ##1 chip_select_n_out && !data_lines_oe_out;
  endproperty
  property p_rd_len;
    $fell(output_gate_n_out) |-> s_rd_pulse;
  endproperty
  property p_rd_rsp;
    en_in && req_valid_in && req_ready_out && !req_write_in |-> ##24 rsp_valid_out;
  endproperty
  property p_rsp_pulse;
    rsp_valid_out |=> !rsp_valid_out;
  endproperty
  property p_page_keep;
    en_in && req_valid_in && req_ready_out && busy_out
      |-> req_write_in && req_addr_in[14:6] == byte_address_out[14:6];
  endproperty
  property p_idle_pins;
    !busy_out |-> chip_select_n_out && write_strobe_n_out && !data_lines_oe_out;
  endproperty
  a_we_width: assert property (p_we_width) else $error("strobe width wrong");
  a_wr_gate: assert property (p_wr_gate) else $error("strobe while gated");
  a_no_fight: assert property (p_no_fight) else $error("drive during read");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  a_data_hold: assert property (p_data_hold) else $error("data released early");
  a_rd_len: assert property (p_rd_len) else $error("read length wrong");
  a_rd_rsp: assert property (p_rd_rsp) else $error("read answer late");
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer too long");
  a_page_keep: assert property (p_page_keep) else $error("page changed");
  a_idle_pins: assert property (p_idle_pins) else $error("pins busy in idle");
endmodule : pew_host_asserts

// file: tb/pew_host_tb.sv
// ****************************************
// host controller bench
// ****************************************
module pew_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned LWIN = 200;
  localparam int unsigned PMAX = 5000;
  logic clk_in, rst_in, en_in, req_valid_in, req_write_in, req_last_in, prot, hang;
  logic [14:0] req_addr_in, byte_address_out;
  logic [7:0] req_data_in, rsp_data_out, data_lines_out, bus;
  logic [1:0] rsp_status_out;
  logic req_ready_out, rsp_valid_out, busy_out, data_lines_oe_out;
  logic chip_select_n_out, output_gate_n_out, write_strobe_n_out;
  int miscompares = 0;
  int check_count = 0;
  pew_host #(.LOAD_WINDOW_CYC(LWIN), .PROG_MAX_CYC(PMAX)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .en_in(en_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_write_in(req_write_in), .req_last_in(req_last_in),
    .req_addr_in(req_addr_in), .req_data_in(req_data_in), .rsp_valid_out(rsp_valid_out),
    .rsp_data_out(rsp_data_out), .rsp_status_out(rsp_status_out), .busy_out(busy_out),
    .chip_select_n_out(chip_select_n_out), .output_gate_n_out(output_gate_n_out),
    .write_strobe_n_out(write_strobe_n_out), .byte_address_out(byte_address_out),
    .data_lines_out(data_lines_out), .data_lines_oe_out(data_lines_oe_out),
    .data_lines_in(bus));
  pew_mem_model #(.WIN(LWIN), .PROG(600)) u_mem (
    .clk_in(clk_in), .ce_n_in(chip_select_n_out), .oe_n_in(output_gate_n_out),
    .we_n_in(write_strobe_n_out), .addr_in(byte_address_out), .host_d_in(data_lines_out),
    .host_oe_in(data_lines_oe_out), .prot_in(prot), .hang_in(hang), .bus_out(bus));
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_flag(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_flag
  // one request, held until the port takes it
  task automatic req(input logic w, input logic l, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    #1;
    req_write_in = w;
    req_last_in = l;
    req_addr_in = a;
    req_data_in = d;
    req_valid_in = 1'b1;
    @(negedge clk_in);
    while (req_ready_out !== 1'b1 && n < 5000) begin
      @(negedge clk_in);
      n++;
    end
    @(posedge clk_in);
    #1;
    req_valid_in = 1'b0;
  endtask : req
  // wait a bounded time for the answer pulse, then judge it
  task automatic wait_rsp(input logic [7:0] d, input logic [1:0] st);
    int n;
    n = 0;
    while (rsp_valid_out !== 1'b1 && n < 6000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    cmp_flag({1'b0, rsp_valid_out}, 2'h1);
    cmp_byte(rsp_data_out, d);
    cmp_flag(rsp_status_out, st);
  endtask : wait_rsp
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] d);
    req(1'b0, 1'b0, a, 8'h00);
    wait_rsp(d, 2'h0);
  endtask : rd_chk
  // pins idle and port ready after reset
  task automatic t_reset();
    cmp_flag({chip_select_n_out, write_strobe_n_out}, 2'h3);
    cmp_flag({output_gate_n_out, data_lines_oe_out}, 2'h2);
    cmp_flag({busy_out, req_ready_out}, 2'h1);
    // enable low: a waiting read must not start
    en_in = 1'b0;
    req_valid_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    cmp_flag({busy_out, chip_select_n_out}, 2'h1);
    req_valid_in = 1'b0;
    en_in = 1'b1;
    $display("test reset done");
  endtask : t_reset
  // three loads in one page, closed by the last flag
  task automatic t_page();
    req(1'b1, 1'b0, 15'h0140, 8'h3C);
    req(1'b1, 1'b0, 15'h017F, 8'hA5);
    req(1'b1, 1'b1, 15'h0155, 8'h5A);
    wait_rsp(8'h5A, 2'h0);
    rd_chk(15'h0140, 8'h3C);
    rd_chk(15'h017F, 8'hA5);
    rd_chk(15'h0155, 8'h5A);
    $display("test page done");
  endtask : t_page
  // a full page at the top of the array closes on its own
  task automatic t_full();
    for (int i = 0; i < 64; i++) begin
      req(1'b1, 1'b0, 15'h7FC0 + 15'(i), 8'h96 ^ 8'(i));
    end
    wait_rsp(8'hA9, 2'h0);
    rd_chk(15'h7FC0, 8'h96);
    rd_chk(15'h7FFF, 8'hA9);
    $display("test full page done");
  endtask : t_full
  // a read request closes an open page, then must wait its turn
  task automatic t_window();
    req(1'b1, 1'b0, 15'h0200, 8'h81);
    @(posedge clk_in);
    #1;
    req_write_in = 1'b0;
    req_valid_in = 1'b1;
    repeat (40) @(negedge clk_in);
    cmp_flag({busy_out, req_ready_out}, 2'h2);
    wait_rsp(8'h81, 2'h0);
    rd_chk(15'h0200, 8'h81);
    $display("test window done");
  endtask : t_window
  // a write to a protected part shows no complement and is flagged
  task automatic t_protect();
    prot = 1'b1;
    req(1'b1, 1'b1, 15'h0300, 8'h11);
    wait_rsp(8'hFF, 2'h2);
    prot = 1'b0;
    rd_chk(15'h0300, 8'hFF);
    $display("test protect done");
  endtask : t_protect
  // a part that never finishes must end in the timeout status
  task automatic t_stall();
    int n;
    n = 0;
    hang = 1'b1;
    req(1'b1, 1'b1, 15'h0400, 8'h00);
    while (rsp_valid_out !== 1'b1 && n < 6000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    hang = 1'b0;
    cmp_flag({1'b0, rsp_valid_out}, 2'h1);
    cmp_byte(rsp_data_out | 8'h40, 8'hFF);
    cmp_flag(rsp_status_out, 2'h1);
    // timeout skips recovery, so let the released part finish first
    repeat (700) @(posedge clk_in);
    rd_chk(15'h0400, 8'h00);
    $display("test stall done");
  endtask : t_stall
  // free-running clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // reset, then the scenarios in turn
  initial begin
    {rst_in, en_in, req_valid_in, req_write_in, req_last_in, prot} = 6'h30;
    hang = 1'b0;
    req_addr_in = 15'h0000;
    req_data_in = 8'h00;
    repeat (5) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    t_reset();
    t_page();
    t_full();
    t_window();
    t_protect();
    t_stall();
    close_out();
  end
  // watchdog well past the expected run of some fifteen thousand cycles
  initial begin
    #600000;
    miscompares++;
    $display("watchdog expired");
    close_out();
  end
endmodule : pew_host_tb
bind pew_host pew_host_asserts u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .en_in(en_in), .req_valid_in(req_valid_in),
  .req_ready_out(req_ready_out), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
  .rsp_valid_out(rsp_valid_out), .busy_out(busy_out), .chip_select_n_out(chip_select_n_out),
  .output_gate_n_out(output_gate_n_out), .write_strobe_n_out(write_strobe_n_out),
  .byte_address_out(byte_address_out), .data_lines_out(data_lines_out),
  .data_lines_oe_out(data_lines_oe_out));

// file: tb/pew_mem_model.sv
// ****************************************
// behavioural byte-wide memory at the pins
// ****************************************
module pew_mem_model #(
  parameter int WIN = 200,
  parameter int PROG = 600
) (
  // clock for self-timed counts
  input wire logic clk_in,
  // host pins
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [14:0] addr_in,
  input wire logic [7:0] host_d_in,
  input wire logic host_oe_in,
  // protected state or low supply, and a stuck programming cycle, set by the bench
  input wire logic prot_in,
  input wire logic hang_in,
  // resolved data lines
  output logic [7:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:32767];
  logic [7:0] pg [0:63];
  logic [63:0] pv = '0;
  logic [14:0] lat_a;
  logic [14:0] last_a;
  logic [7:0] last_d;
  logic [8:0] pa;
  logic [7:0] held = 8'h00;
  logic [7:0] rdv;
  logic tog = 1'b0;
  logic loading = 1'b0;
  int win;
  int prog = 0;
  time t_fall;
  wire wr = !ce_n_in && !we_n_in && oe_n_in;
  wire rd = !ce_n_in && !oe_n_in;
  // erased array
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // address taken when the later strobe falls; window restarts
  always @(posedge wr) begin
    lat_a = addr_in;
    t_fall = $time;
    win = WIN;
  end
  // data taken when the first strobe rises; glitches and busy time ignored
  always @(negedge wr) begin
    if (!prot_in && prog == 0 && $time - t_fall >= 20) begin
      if (!loading) pa = lat_a[14:6];
      pg[lat_a[5:0]] = host_d_in;
      pv[lat_a[5:0]] = 1'b1;
      last_a = lat_a;
      last_d = host_d_in;
      loading = 1'b1;
    end
  end
  // load window, then programming, then commit of the loaded bytes of the page
  always @(posedge clk_in) begin
    held <= bus_out;
    if (loading && win > 0) win--;
    else if (loading) begin
      loading = 1'b0;
      prog = PROG;
    end else if (prog == 1) begin
      foreach (pv[i]) if (pv[i]) mem[{pa, 6'(i)}] = pg[i];
      pv = '0;
      prog = 0;
    end else if (prog > 0 && !hang_in) prog--;
  end
  // status bits replace stored data while busy
  always_comb begin
    rdv = mem[addr_in];
    if (loading || prog > 0) begin
      rdv[6] = tog;
      if (addr_in == last_a) rdv[7] = ~last_d[7];
    end
  end
  // bit six flips at the end of each busy read
  always @(negedge rd) if (loading || prog > 0) tog = ~tog;
  // undriven lines show a moving pattern, never the last value
  assign bus_out = host_oe_in ? host_d_in : rd ? rdv : ~held;
endmodule : pew_mem_model

// file: verilog/pew_host.sv
`include "pew_map.svh"

module pew_host #(
  parameter int unsigned LOAD_WINDOW_CYC = `PEW_BLC_MAX_NS / `PEW_CLK_NS,
  parameter int unsigned PROG_MAX_CYC = `PEW_WC_MAX_NS / `PEW_CLK_NS
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  // user request
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic req_write_in,
  input wire logic req_last_in,
  input wire logic [`PEW_ADDR_W-1:0] req_addr_in,
  input wire logic [`PEW_DATA_W-1:0] req_data_in,
  // user response
  output logic rsp_valid_out,
  output logic [`PEW_DATA_W-1:0] rsp_data_out,
  output logic [1:0] rsp_status_out,
  output logic busy_out,
  // memory pins
  output logic chip_select_n_out,
  output logic output_gate_n_out,
  output logic write_strobe_n_out,
  output logic [`PEW_ADDR_W-1:0] byte_address_out,
  output logic [`PEW_DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_out,
  input wire logic [`PEW_DATA_W-1:0] data_lines_in
);

  // ****************************************
  // data pin synchroniser
  // ****************************************
  logic [`PEW_DATA_W-1:0] s1_reg, s2_reg, s3_reg, stable_reg, stable_next;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stable_reg <= '0;
    end else if (en_in) begin
      s1_reg <= data_lines_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_reg <= stable_next;
    end
  end

  // a bit only moves once two stages agree, filtering pin glitches
  for (genvar b = 0; b < `PEW_DATA_W; b++) begin : g_agree
    always_comb begin
      stable_next[b] = (s2_reg[b] == s3_reg[b]) ? s3_reg[b] : stable_reg[b];
    end
  end

  // ****************************************
  // sequencer state
  // ****************************************
  pew_tmr_if tmr_if ();

  pew_timer u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .en_in(en_in),
    .tmr(tmr_if.tmr)
  );

  pew_pkg::pew_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [`PEW_ADDR_W-1:0] addr_reg, addr_next;
  logic [`PEW_DATA_W-1:0] wdata_reg, wdata_next, rd_reg, rd_next;
  logic [6:0] bytes_reg, bytes_next;
  logic last_reg, last_next, poll_reg, poll_next, first_reg, first_next;
  logic prev6_reg, prev6_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [`PEW_DATA_W-1:0] rsp_data_reg, rsp_data_next;
  logic [1:0] rsp_status_reg, rsp_status_next;
  logic ce_n_reg, oe_n_reg, we_n_reg, doe_reg;
  logic same_page;

  assign same_page = (req_addr_in[`PEW_ADDR_W-1:`PEW_PAGE_LSB] ==
                      addr_reg[`PEW_ADDR_W-1:`PEW_PAGE_LSB]);

  // handshake is combinational; only clean same-page writes join a page
  always_comb begin
    req_ready_out = 1'b0;
    if (state_reg == pew_pkg::PEW_IDLE) begin
      req_ready_out = 1'b1;
    end else if (state_reg == pew_pkg::PEW_LOAD_OPEN) begin
      req_ready_out = req_write_in && same_page && !tmr_if.expired;
    end
  end

  // next state and datapath
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 8'h01;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rd_next = rd_reg;
    bytes_next = bytes_reg;
    last_next = last_reg;
    poll_next = poll_reg;
    first_next = first_reg;
    prev6_next = prev6_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    rsp_status_next = rsp_status_reg;
    tmr_if.load = 1'b0;
    tmr_if.value = '0;
    case (state_reg)
      pew_pkg::PEW_IDLE: begin
        if (req_valid_in) begin
          addr_next = req_addr_in;
          wdata_next = req_data_in;
          cnt_next = 8'h00;
          poll_next = 1'b0;
          if (req_write_in) begin
            bytes_next = 7'h01;
            last_next = req_last_in;
            state_next = pew_pkg::PEW_WR_LOW;
          end else begin
            state_next = pew_pkg::PEW_RD_ACT;
          end
        end
      end
      pew_pkg::PEW_RD_ACT: begin
        // full access time plus synchroniser before sampling
        if (cnt_reg == 8'(`PEW_RD_CYC - 1)) begin
          rd_next = stable_next;
          cnt_next = 8'h00;
          state_next = pew_pkg::PEW_RD_END;
        end
      end
      pew_pkg::PEW_RD_END: begin
        // bus turnaround before anything else may drive the data pins
        if (cnt_reg == 8'(`PEW_OHZ_CYC - 1)) begin
          cnt_next = 8'h00;
          if (!poll_reg) begin
            rsp_valid_next = 1'b1;
            rsp_data_next = rd_reg;
            rsp_status_next = `PEW_ST_OK;
            state_next = pew_pkg::PEW_IDLE;
          end else if (!first_reg && rd_reg[`PEW_TOGGLE_BIT] == prev6_reg) begin
            rsp_valid_next = 1'b1;
            rsp_data_next = rd_reg;
            if (rd_reg[`PEW_POLL_BIT] == wdata_reg[`PEW_POLL_BIT]) begin
              rsp_status_next = `PEW_ST_OK;
            end else begin
              rsp_status_next = `PEW_ST_PROTECTED;
            end
            tmr_if.load = 1'b1;
            tmr_if.value = `PEW_TMR_W'(`PEW_DW_CYC);
            state_next = pew_pkg::PEW_RECOVER;
          end else if (tmr_if.expired) begin
            rsp_valid_next = 1'b1;
            rsp_data_next = rd_reg;
            rsp_status_next = `PEW_ST_TIMEOUT;
            state_next = pew_pkg::PEW_IDLE;
          end else begin
            first_next = 1'b0;
            prev6_next = rd_reg[`PEW_TOGGLE_BIT];
            state_next = pew_pkg::PEW_RD_ACT;
          end
        end
      end
      pew_pkg::PEW_WR_LOW: begin
        if (cnt_reg == 8'h00) begin
          // window counts from this falling strobe
          tmr_if.load = 1'b1;
          tmr_if.value = `PEW_TMR_W'(LOAD_WINDOW_CYC - `PEW_LOAD_MARGIN_CYC);
        end
        if (cnt_reg == 8'(`PEW_WP_CYC - 1)) begin
          cnt_next = 8'h00;
          state_next = pew_pkg::PEW_WR_RISE;
        end
      end
      pew_pkg::PEW_WR_RISE: begin
        // strobe rises first; data and select hold behind it
        if (cnt_reg == 8'(`PEW_DH_CYC - 1)) begin
          cnt_next = 8'h00;
          state_next = pew_pkg::PEW_WR_GAP;
        end
      end
      pew_pkg::PEW_WR_GAP: begin
        if (cnt_reg == 8'(`PEW_WPH_CYC - 1)) begin
          cnt_next = 8'h00;
          if (last_reg || bytes_reg == 7'(`PEW_PAGE_BYTES)) begin
            state_next = pew_pkg::PEW_SETTLE;
          end else begin
            state_next = pew_pkg::PEW_LOAD_OPEN;
          end
        end
      end
      pew_pkg::PEW_LOAD_OPEN: begin
        if (req_valid_in && req_ready_out) begin
          addr_next = req_addr_in;
          wdata_next = req_data_in;
          bytes_next = bytes_reg + 7'h01;
          last_next = req_last_in;
          cnt_next = 8'h00;
          state_next = pew_pkg::PEW_WR_LOW;
        end else if (req_valid_in || tmr_if.expired) begin
          // foreign request or idle page: close it, request waits
          cnt_next = 8'h00;
          state_next = pew_pkg::PEW_SETTLE;
        end
      end
      pew_pkg::PEW_SETTLE: begin
        // a full window guarantees programming started before polling
        if (cnt_reg == 8'h00) begin
          tmr_if.load = 1'b1;
          tmr_if.value = `PEW_TMR_W'(LOAD_WINDOW_CYC);
        end else if (tmr_if.expired) begin
          tmr_if.load = 1'b1;
          tmr_if.value = `PEW_TMR_W'(PROG_MAX_CYC);
          poll_next = 1'b1;
          first_next = 1'b1;
          cnt_next = 8'h00;
          state_next = pew_pkg::PEW_RD_ACT;
        end else begin
          cnt_next = cnt_reg; // a wrap to zero would reload the window forever
        end
      end
      pew_pkg::PEW_RECOVER: begin
        if (tmr_if.expired) begin
          state_next = pew_pkg::PEW_IDLE;
        end
      end
      default: begin
        state_next = pew_pkg::PEW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= pew_pkg::PEW_IDLE;
      cnt_reg <= 8'h00;
      addr_reg <= '0;
      wdata_reg <= '0;
      rd_reg <= '0;
      bytes_reg <= 7'h00;
      last_reg <= 1'b0;
      poll_reg <= 1'b0;
      first_reg <= 1'b0;
      prev6_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= '0;
      rsp_status_reg <= 2'h0;
    end else if (en_in) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rd_reg <= rd_next;
      bytes_reg <= bytes_next;
      last_reg <= last_next;
      poll_reg <= poll_next;
      first_reg <= first_next;
      prev6_reg <= prev6_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      rsp_status_reg <= rsp_status_next;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  logic ce_n_next, oe_n_next, we_n_next, doe_next;

  // pins follow the next state so they change on the state edge itself
  always_comb begin
    ce_n_next = !(state_next == pew_pkg::PEW_RD_ACT || state_next == pew_pkg::PEW_WR_LOW ||
                  state_next == pew_pkg::PEW_WR_RISE);
    oe_n_next = !(state_next == pew_pkg::PEW_RD_ACT);
    we_n_next = !(state_next == pew_pkg::PEW_WR_LOW);
    doe_next = (state_next == pew_pkg::PEW_WR_LOW || state_next == pew_pkg::PEW_WR_RISE);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      doe_reg <= 1'b0;
    end else if (en_in) begin
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      doe_reg <= doe_next;
    end
  end

  assign chip_select_n_out = ce_n_reg;
  assign output_gate_n_out = oe_n_reg;
  assign write_strobe_n_out = we_n_reg;
  assign byte_address_out = addr_reg;
  assign data_lines_out = wdata_reg;
  assign data_lines_oe_out = doe_reg;
  assign rsp_valid_out = rsp_valid_reg;
  assign rsp_data_out = rsp_data_reg;
  assign rsp_status_out = rsp_status_reg;
  assign busy_out = (state_reg != pew_pkg::PEW_IDLE);

endmodule : pew_host

// file: verilog/pew_timer.sv
`include "pew_map.svh"

// ****************************************
// down counter for windows and timeouts
// ****************************************
module pew_timer (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  // control
  pew_tmr_if.tmr tmr
);

  pew_pkg::pew_tick_t cnt_reg;
  pew_pkg::pew_tick_t cnt_next;

  // reload wins over counting so a new interval never inherits a stale tail
  always_comb begin
    cnt_next = cnt_reg;
    if (tmr.load) begin
      cnt_next = tmr.value;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - `PEW_TMR_W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
    end else if (en_in) begin
      cnt_reg <= cnt_next;
    end
  end

  assign tmr.expired = (cnt_reg == '0);

endmodule : pew_timer
